// ---- hw/dinfilt_diag.sv ----
// Input filters, parameter records and diagnostic record of 8 inputs
`timescale 1ns/10ps
`include "dinfilt_cfg.svh"

module dinfilt_diag #(
  parameter logic [18:0] FILT_CYC_2 = 19'(`FILT_US_2 * `US_CYC),
  parameter logic [18:0] FILT_CYC_3 = 19'(`FILT_US_3 * `US_CYC),
  parameter logic [18:0] FILT_CYC_4 = 19'(`FILT_US_4 * `US_CYC),
  parameter logic [18:0] FILT_CYC_5 = 19'(`FILT_US_5 * `US_CYC),
  parameter logic [18:0] FILT_CYC_6 = 19'(`FILT_US_6 * `US_CYC),
  parameter logic [18:0] FILT_CYC_7 = 19'(`FILT_US_7 * `US_CYC)
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // Field side
  input wire logic [7:0] i_input_channel_n,
  input wire logic [7:0] i_wire_break,
  input wire logic i_aux_missing,
  input wire logic i_comm_error,
  input wire logic i_module_fault,
  // Coupler side
  input wire logic i_stop_state,
  input wire logic i_rec_lock,
  input wire logic i_irq_ack,
  input wire dinfilt_pkg::rec_req_t i_req,
  output dinfilt_pkg::rec_rsp_t o_rsp,
  output logic o_diag_irq,
  // Filtered process inputs
  output logic [7:0] o_input_state
);
  import dinfilt_pkg::*;

  localparam logic [18:0] FILT_CYC_1 = 19'(`FILT_US_1 * `US_CYC);
  localparam logic [4:0] US_LAST = 5'(`US_CYC - 1);

  // Field inputs: 8 channels, 8 wire-break, aux, comm, fault
  localparam int NSYNC = 19;

  logic [NSYNC-1:0] raw_in;
  logic [NSYNC-1:0] s1_reg;
  logic [NSYNC-1:0] s2_reg;
  logic [NSYNC-1:0] s3_reg;
  logic [NSYNC-1:0] agreed_reg;

  assign raw_in = {i_module_fault, i_comm_error, i_aux_missing,
                   i_wire_break, i_input_channel_n};

  // A field change counts only once the second and third stages agree
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      agreed_reg <= '0;
    end else begin
      s1_reg <= raw_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      agreed_reg <= (s2_reg & s3_reg) | (agreed_reg & (s2_reg | s3_reg));
    end
  end

  // Parameter records
  logic [7:0] diag_interrupt_enable_reg;
  logic [7:0] wire_break_enable_reg;
  logic [7:0] filter_time_reg [4];
  logic param_error_reg;

  function automatic logic nib_ok(input logic [3:0] n);
    return (n >= 4'h1) && (n <= 4'h7);
  endfunction

  function automatic logic [18:0] filt_cycles(input logic [3:0] n);
    case (n)
      4'h2: return FILT_CYC_2;
      4'h3: return FILT_CYC_3;
      4'h4: return FILT_CYC_4;
      4'h5: return FILT_CYC_5;
      4'h6: return FILT_CYC_6;
      4'h7: return FILT_CYC_7;
      default: return FILT_CYC_1;
    endcase
  endfunction

  // Request decode to a target byte
  tgt_t tgt;
  logic [4:0] tgt_byte;
  logic tgt_wr_ok;

  always_comb begin
    tgt = TGT_NONE;
    tgt_byte = '0;
    case (i_req.mode)
      ACC_RECORD: begin
        if (i_req.wr && i_req.record_set_number == `DS_PARAM &&
            i_req.offset < 5'd2) begin
          tgt = TGT_PARAM;
          tgt_byte = i_req.offset;
        end else if (i_req.record_set_number >= `DS_FILT0 &&
                     i_req.record_set_number <= `DS_FILT3 &&
                     i_req.offset == 5'd0) begin
          tgt = TGT_PARAM;
          tgt_byte = 5'(i_req.record_set_number - `DS_FILT0) + 5'd2;
        end else if (i_req.rd &&
                     i_req.record_set_number == `DS_DIAG_SHORT &&
                     i_req.offset < `DIAG_SHORT_LEN) begin
          tgt = TGT_DIAG;
          tgt_byte = i_req.offset;
        end else if (i_req.rd &&
                     i_req.record_set_number == `DS_DIAG_FULL &&
                     i_req.offset < `DIAG_LEN) begin
          tgt = TGT_DIAG;
          tgt_byte = i_req.offset;
        end
      end
      ACC_CANOPEN: begin
        if (i_req.object_index >= `IX_PARAM0 &&
            i_req.object_index <= `IX_PARAM5 && i_req.offset == 5'd0) begin
          tgt = TGT_PARAM;
          tgt_byte = 5'(i_req.object_index - `IX_PARAM0);
        end else if (i_req.rd && i_req.object_index == `IX_DIAG_SHORT &&
                     i_req.offset < `DIAG_SHORT_LEN) begin
          tgt = TGT_DIAG;
          tgt_byte = i_req.offset;
        end else if (i_req.rd && i_req.object_index == `IX_DIAG_FULL &&
                     i_req.offset < `DIAG_LEN) begin
          tgt = TGT_DIAG;
          tgt_byte = i_req.offset;
        end
      end
      ACC_ETHERCAT: begin
        if (i_req.object_index == `EC_PARAM &&
            i_req.object_subindex >= `SX_PARAM_FIRST &&
            i_req.object_subindex <= `SX_PARAM_LAST &&
            i_req.offset == 5'd0) begin
          tgt = TGT_PARAM;
          tgt_byte = 5'(i_req.object_subindex - `SX_PARAM_FIRST);
        end else if (i_req.rd && i_req.object_index == `EC_DIAG &&
                     i_req.object_subindex >= `SX_DIAG_FIRST &&
                     i_req.object_subindex <= `SX_DIAG_LAST &&
                     i_req.offset == 5'd0) begin
          tgt = TGT_DIAG;
          tgt_byte = 5'(i_req.object_subindex - `SX_DIAG_FIRST);
        end else if (i_req.rd && i_req.object_index == `EC_DIAG &&
                     i_req.object_subindex == `SX_DIAG_TS &&
                     i_req.offset < 5'd4) begin
          tgt = TGT_DIAG;
          tgt_byte = `DIAG_TS_BYTE + i_req.offset;
        end
      end
      default: begin
        tgt = TGT_NONE;
      end
    endcase
  end

  // Value checks on parameter writes
  always_comb begin
    tgt_wr_ok = 1'b1;
    if (tgt_byte == 5'd0) begin
      tgt_wr_ok = (i_req.wdata == `DIAG_INTERRUPT_ENABLE_OFF) ||
                  (i_req.wdata == `DIAG_INTERRUPT_ENABLE_ON);
    end else if (tgt_byte >= 5'd2) begin
      tgt_wr_ok = nib_ok(i_req.wdata[3:0]) &&
                  nib_ok(i_req.wdata[7:4]);
    end
    // The two enable bytes only change while the system is stopped
    if (tgt_byte < 5'd2 && !i_stop_state) begin
      tgt_wr_ok = 1'b0;
    end
  end

  logic do_wr;
  logic wr_reject;

  assign do_wr = i_req.wr && tgt == TGT_PARAM && tgt_wr_ok;
  assign wr_reject = i_req.wr && tgt == TGT_PARAM && !tgt_wr_ok &&
                     (tgt_byte >= 5'd2 || i_stop_state);

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      diag_interrupt_enable_reg <= `DIAG_INTERRUPT_ENABLE_RST;
      wire_break_enable_reg <= `WB_EN_RST;
      for (int k = 0; k < 4; k++) begin
        filter_time_reg[k] <= `FILT_RST;
      end
    end else if (do_wr) begin
      case (tgt_byte)
        5'd0: diag_interrupt_enable_reg <= i_req.wdata;
        5'd1: wire_break_enable_reg <= i_req.wdata;
        5'd2: filter_time_reg[0] <= i_req.wdata;
        5'd3: filter_time_reg[1] <= i_req.wdata;
        5'd4: filter_time_reg[2] <= i_req.wdata;
        5'd5: filter_time_reg[3] <= i_req.wdata;
        default: ;
      endcase
    end
  end

  // Sticky until the next accepted parameter write
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      param_error_reg <= 1'b0;
    end else if (wr_reject) begin
      param_error_reg <= 1'b1;
    end else if (do_wr) begin
      param_error_reg <= 1'b0;
    end
  end

  // Input filters: a new level must hold for the full filter time
  logic [18:0] filt_cnt_reg [8];

  generate
    for (genvar c = 0; c < 8; c++) begin : g_filt
      logic [3:0] nib;
      logic [18:0] limit;
      assign nib = c[0] ? filter_time_reg[c/2][7:4] :
                          filter_time_reg[c/2][3:0];
      assign limit = filt_cycles(nib);

      always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
          filt_cnt_reg[c] <= '0;
          o_input_state[c] <= 1'b0;
        end else if (agreed_reg[c] == o_input_state[c]) begin
          filt_cnt_reg[c] <= '0;
        end else if (filt_cnt_reg[c] >= limit - 19'd1) begin
          filt_cnt_reg[c] <= '0;
          o_input_state[c] <= agreed_reg[c];
        end else begin
          filt_cnt_reg[c] <= filt_cnt_reg[c] + 19'd1;
        end
      end
    end
  endgenerate

  // Microsecond ticker
  logic [4:0] us_pre_reg;
  logic [31:0] us_ticker_reg;

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      us_pre_reg <= '0;
      us_ticker_reg <= '0;
    end else if (us_pre_reg == US_LAST) begin
      us_pre_reg <= '0;
      us_ticker_reg <= us_ticker_reg + 32'd1;
    end else begin
      us_pre_reg <= us_pre_reg + 5'd1;
    end
  end

  // Error flags
  logic [7:0] channel_err;
  logic [7:0] diag_a;
  logic [7:0] diag_d;
  logic overflow_reg;
  logic [15:0] flags;
  logic [15:0] flags_prev_reg;
  logic new_event;

  assign channel_err = agreed_reg[15:8] & wire_break_enable_reg;
  assign diag_d = {3'b000, agreed_reg[17], overflow_reg, 3'b000};

  always_comb begin
    diag_a = 8'h00;
    diag_a[`A_MOD_FAIL] = agreed_reg[18];
    diag_a[`A_INTERNAL] = |diag_d;
    diag_a[`A_EXTERNAL] = (|channel_err) | agreed_reg[16];
    diag_a[`A_CHANNEL] = |channel_err;
    diag_a[`A_AUX] = agreed_reg[16];
    diag_a[`A_PARAM] = param_error_reg;
  end

  assign flags = {diag_a, channel_err};
  assign new_event = |(flags & ~flags_prev_reg);

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      flags_prev_reg <= '0;
    end else begin
      flags_prev_reg <= flags;
    end
  end

  // An event arriving while the last one is still unacknowledged overflows
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      overflow_reg <= 1'b0;
    end else if (new_event && o_diag_irq) begin
      overflow_reg <= 1'b1;
    end else if (i_irq_ack) begin
      overflow_reg <= 1'b0;
    end
  end

  // Set wins over acknowledge in the same cycle
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_diag_irq <= 1'b0;
    end else if (new_event &&
                 diag_interrupt_enable_reg == `DIAG_INTERRUPT_ENABLE_ON) begin
      o_diag_irq <= 1'b1;
    end else if (i_irq_ack) begin
      o_diag_irq <= 1'b0;
    end
  end

  // Timestamp: shadow catches the event, visible copy moves when unlocked
  logic [31:0] ts_shadow_reg;
  logic ts_pending_reg;
  logic [31:0] diag_timestamp_reg;

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ts_shadow_reg <= '0;
      ts_pending_reg <= 1'b0;
      diag_timestamp_reg <= '0;
    end else begin
      if (new_event) begin
        ts_shadow_reg <= us_ticker_reg;
      end
      if (new_event && i_rec_lock) begin
        ts_pending_reg <= 1'b1;
      end else if (!i_rec_lock) begin
        ts_pending_reg <= 1'b0;
      end
      if (!i_rec_lock && new_event) begin
        diag_timestamp_reg <= us_ticker_reg;
      end else if (!i_rec_lock && ts_pending_reg) begin
        diag_timestamp_reg <= ts_shadow_reg;
      end
    end
  end

  // Read mux
  logic [7:0] rd_byte;

  always_comb begin
    rd_byte = 8'h00;
    if (tgt == TGT_PARAM) begin
      case (tgt_byte)
        5'd0: rd_byte = diag_interrupt_enable_reg;
        5'd1: rd_byte = wire_break_enable_reg;
        5'd2: rd_byte = filter_time_reg[0];
        5'd3: rd_byte = filter_time_reg[1];
        5'd4: rd_byte = filter_time_reg[2];
        5'd5: rd_byte = filter_time_reg[3];
        default: rd_byte = 8'h00;
      endcase
    end else if (tgt == TGT_DIAG) begin
      case (tgt_byte)
        5'd0: rd_byte = diag_a;
        5'd1: rd_byte = `MODULE_INFO;
        5'd2: rd_byte = 8'h00;
        5'd3: rd_byte = diag_d;
        5'd4: rd_byte = `CHANNEL_KIND;
        5'd5: rd_byte = `DIAG_BITS_PER_CH;
        5'd6: rd_byte = `CHANNEL_COUNT;
        5'd7: rd_byte = channel_err;
        5'd16: rd_byte = diag_timestamp_reg[7:0];
        5'd17: rd_byte = diag_timestamp_reg[15:8];
        5'd18: rd_byte = diag_timestamp_reg[23:16];
        5'd19: rd_byte = diag_timestamp_reg[31:24];
        default: begin
          if (tgt_byte >= 5'd8 && tgt_byte <= 5'd15) begin
            rd_byte[`CH_WIRE_BREAK] = channel_err[tgt_byte[2:0]];
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rsp <= '0;
    end else begin
      o_rsp.valid <= i_req.rd | i_req.wr;
      o_rsp.err <= (i_req.rd | i_req.wr) &&
                   (tgt == TGT_NONE || (i_req.wr && !tgt_wr_ok));
      o_rsp.rdata <= i_req.rd ? rd_byte : 8'h00;
    end
  end
endmodule

// ---- hw/dinfilt_cfg.svh ----
// Constants of the eight-channel input filter and diagnostic block
// Operation
// - Interrupt enable byte takes 00h (off) or 40h (on); resets to 00h.
// - Wire-break enable bit n switches on detection for channel n.
// - Filter byte low nibble sets even channel, high nibble next odd.
// - Nibble codes 1h..7h select 100us to 20ms; other codes forbidden.
// - Four filter bytes, record sets 80h..83h, each defaulting to 11h.
// - Each input is delayed by its filter time to suppress spikes.
// - Diagnostic byte 0 flags module, internal, external, channel, parameter.
// - Diagnostic byte 0 bit 4 flags missing auxiliary supply.
// - Diagnostic byte 3 flags buffer overflow (bit 3), comm error (bit 4).
// - Module information byte reads 1Fh.
// - Channel type byte reads 70h.
// - Record reports 08h diagnostic bits per channel.
// - Record reports 08h channels.
// - Channel error summary bit n follows channel n error.
// - Per-channel error byte bit 4 flags wire break.
// - Wire breaks count only on channels with detection enabled.
// - Free-running 32-bit microsecond counter from 0, wrapping.
// - Last four record bytes hold counter value at the event.
// - Record set 01h reads full record, 00h its first four bytes.
// - CANopen index 2F01h reads full record, 2F00h first four bytes.
// - EtherCAT index 3100h subs 01h..06h for parameters, 5005h diagnostics.
`ifndef DINFILT_CFG_SVH
`define DINFILT_CFG_SVH

`define CLK_MHZ 25
`define US_CYC (`CLK_MHZ)
`define FILT_US_1 100
`define FILT_US_2 400
`define FILT_US_3 800
`define FILT_US_4 1600
`define FILT_US_5 3200
`define FILT_US_6 10000
`define FILT_US_7 20000

`define DIAG_INTERRUPT_ENABLE_OFF 8'h00
`define DIAG_INTERRUPT_ENABLE_ON 8'h40
`define DIAG_INTERRUPT_ENABLE_RST 8'h00
`define WB_EN_RST 8'h00
`define FILT_RST 8'h11

`define DS_DIAG_SHORT 8'h00
`define DS_DIAG_FULL 8'h01
`define DS_PARAM 8'h00
`define DS_FILT0 8'h80
`define DS_FILT3 8'h83
`define IX_PARAM0 16'h3100
`define IX_PARAM5 16'h3105
`define IX_DIAG_SHORT 16'h2f00
`define IX_DIAG_FULL 16'h2f01
`define EC_PARAM 16'h3100
`define EC_DIAG 16'h5005
`define SX_PARAM_FIRST 8'h01
`define SX_PARAM_LAST 8'h06
`define SX_DIAG_FIRST 8'h02
`define SX_DIAG_LAST 8'h11
`define SX_DIAG_TS 8'h13

`define DIAG_SHORT_LEN 5'd4
`define DIAG_LEN 5'd20
`define DIAG_TS_BYTE 5'd16
`define PARAM_LEN 3'd6

`define A_MOD_FAIL 0
`define A_INTERNAL 1
`define A_EXTERNAL 2
`define A_CHANNEL 3
`define A_AUX 4
`define A_PARAM 7
`define D_OVERFLOW 3
`define D_COMM 4
`define CH_WIRE_BREAK 4

`define MODULE_INFO 8'h1f
`define CHANNEL_KIND 8'h70
`define DIAG_BITS_PER_CH 8'h08
`define CHANNEL_COUNT 8'h08

`endif

// ---- hw/dinfilt_pkg.sv ----
// Types shared by the input filter and diagnostic block
package dinfilt_pkg;
  typedef enum logic [1:0] {
    ACC_RECORD = 2'b00,
    ACC_CANOPEN = 2'b01,
    ACC_ETHERCAT = 2'b10
  } acc_mode_t;

  typedef struct packed {
    logic rd;
    logic wr;
    acc_mode_t mode;
    logic [7:0] record_set_number;
    logic [15:0] object_index;
    logic [7:0] object_subindex;
    logic [4:0] offset;
    logic [7:0] wdata;
  } rec_req_t;

  typedef struct packed {
    logic valid;
    logic err;
    logic [7:0] rdata;
  } rec_rsp_t;

  typedef enum logic [1:0] {
    TGT_NONE = 2'b00,
    TGT_PARAM = 2'b01,
    TGT_DIAG = 2'b10
  } tgt_t;
endpackage

// ---- verification/dinfilt_diag_assertions.sv ----
// Port assertions for the input filter and diagnostic block
`timescale 1ns/10ps
module dinfilt_diag_chk #(
  parameter logic [18:0] FILT_CYC_2 = 19'd10000,
  parameter logic [18:0] FILT_CYC_3 = 19'd20000,
  parameter logic [18:0] FILT_CYC_4 = 19'd40000,
  parameter logic [18:0] FILT_CYC_5 = 19'd80000,
  parameter logic [18:0] FILT_CYC_6 = 19'd250000,
  parameter logic [18:0] FILT_CYC_7 = 19'd500000
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // Coupler side
  input wire logic i_stop_state,
  input wire logic i_irq_ack,
  input wire dinfilt_pkg::rec_req_t i_req,
  input wire dinfilt_pkg::rec_rsp_t o_rsp,
  input wire logic o_diag_irq
);
  import dinfilt_pkg::*;
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rst_n);
  logic req_any, rd_rec, rd_can, rd_eth, bad_nib;
  assign req_any = i_req.rd || i_req.wr;
  assign rd_rec = i_req.rd && i_req.mode == ACC_RECORD;
  assign rd_can = i_req.rd && i_req.mode == ACC_CANOPEN;
  assign rd_eth = i_req.rd && i_req.mode == ACC_ETHERCAT;
  // Nibble 0 or 8..f is outside the legal filter codes
  assign bad_nib = i_req.wdata[3:0] == 4'h0 || i_req.wdata[3] ||
    i_req.wdata[7:4] == 4'h0 || i_req.wdata[7];
  property p_rsp_next;
    req_any |=> o_rsp.valid;
  endproperty
  a_rsp_next: assert property (p_rsp_next) else $error("no answer");
  property p_rsp_cause;
    o_rsp.valid |-> $past(req_any);
  endproperty
  a_rsp_cause: assert property (p_rsp_cause) else $error("stray");
  property p_stop_refuse;
    i_req.wr && !i_stop_state && i_req.mode == ACC_CANOPEN &&
    i_req.object_index inside {16'h3100, 16'h3101} |=> o_rsp.err;
  endproperty
  a_stop_refuse: assert property (p_stop_refuse) else $error("ok");
  property p_bad_code;
    i_req.wr && i_req.mode == ACC_RECORD && bad_nib &&
    i_req.record_set_number inside {[8'h80:8'h83]} |=> o_rsp.err;
  endproperty
  a_bad_code: assert property (p_bad_code) else $error("taken");
  property p_mod_info;
    rd_rec && i_req.record_set_number == 8'h01 && i_req.offset == 5'd1
    |=> o_rsp.rdata == 8'h1f && !o_rsp.err;
  endproperty
  a_mod_info: assert property (p_mod_info) else $error("info");
  property p_ch_kind;
    rd_can && i_req.object_index == 16'h2f01 && i_req.offset == 5'd4
    |=> o_rsp.rdata[6:0] == 7'h70;
  endproperty
  a_ch_kind: assert property (p_ch_kind) else $error("kind");
  property p_counts;
    rd_eth && i_req.object_index == 16'h5005 &&
    i_req.object_subindex inside {8'h07, 8'h08} |=> o_rsp.rdata == 8'h08;
  endproperty
  a_counts: assert property (p_counts) else $error("count");
  property p_unmapped;
    rd_rec && i_req.record_set_number == 8'h05 |=> o_rsp.err;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("mapped");
  property p_irq_fall;
    $fell(o_diag_irq) |-> $past(i_irq_ack);
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq drop");
endmodule

bind dinfilt_diag dinfilt_diag_chk #(
  .FILT_CYC_2(FILT_CYC_2), .FILT_CYC_3(FILT_CYC_3),
  .FILT_CYC_4(FILT_CYC_4), .FILT_CYC_5(FILT_CYC_5),
  .FILT_CYC_6(FILT_CYC_6), .FILT_CYC_7(FILT_CYC_7)
) chk_u (
  .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_stop_state(i_stop_state),
  .i_irq_ack(i_irq_ack), .i_req(i_req), .o_rsp(o_rsp),
  .o_diag_irq(o_diag_irq)
);

// ---- verification/coupler_model.sv ----
// Bus coupler model issuing record transfers
`timescale 1ns/10ps
module coupler_model (
  // Clock
  input wire logic i_clk_sys,
  // Record port
  output dinfilt_pkg::rec_req_t o_req,
  input wire dinfilt_pkg::rec_rsp_t i_rsp,
  // System state
  output logic o_stop_state
);
  import dinfilt_pkg::*;
  initial begin
    o_req = '0;
    o_stop_state = 1'b0;
  end
  task automatic set_stop(input logic s);
    @(negedge i_clk_sys);
    o_stop_state = s;
  endtask
  // One byte a transfer; the mode decides which address fields count
  task automatic xfer(input logic w, input acc_mode_t m,
    input logic [15:0] a, input logic [7:0] s, input logic [4:0] off,
    input logic [7:0] wd, output logic [7:0] rd, output logic er,
    output logic tmo);
    @(negedge i_clk_sys);
    o_req = '{rd: !w, wr: w, mode: m, offset: off, wdata: wd,
      record_set_number: a[7:0],
      object_index: a,
      object_subindex: s};
    @(negedge i_clk_sys);
    tmo = (i_rsp.valid !== 1'b1);
    rd = i_rsp.rdata;
    er = i_rsp.err;
    // Released qualifiers show garbage so stale values cannot pass
    o_req = {2'b00, ~o_req[$bits(rec_req_t)-3:0]};
  endtask
endmodule

// ---- verification/tb_digital_input_filter_diagnostics.sv ----
// Self-checking bench for the input filter and diagnostic block
`timescale 1ns/10ps
module tb_digital_input_filter_diagnostics;
  import dinfilt_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] in_ch = 8'h00;
  logic [7:0] wbrk = 8'h00;
  logic aux = 1'b0;
  logic comm = 1'b0;
  logic fault = 1'b0;
  logic lock = 1'b0;
  logic ack = 1'b0;
  logic stop, irq;
  rec_req_t req;
  rec_rsp_t rsp;
  logic [7:0] state;
  int n_errors = 0;
  int tests_run = 0;
  int cyc = 0;
  logic [31:0] ts1, ts2, ts3;
  logic [7:0] dexp [20] = '{1: 8'h1f, 4: 8'h70, 5: 8'h08, 6: 8'h08,
    default: 8'h00};
  logic [7:0] pexp [6] = '{0: 8'h00, 1: 8'h00, default: 8'h11};

  initial begin
    forever #20 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys)
    cyc <= rst_n ? cyc + 1 : 0;

  // Only codes 2 and 7 are shortened; the other codes keep their real lengths
  dinfilt_diag #(
    .FILT_CYC_2(19'd20), .FILT_CYC_7(19'd40)
  ) dut_u (
    .i_clk_sys(clk_sys), .i_rst_n(rst_n), .i_input_channel_n(in_ch),
    .i_wire_break(wbrk), .i_aux_missing(aux), .i_comm_error(comm),
    .i_module_fault(fault), .i_stop_state(stop), .i_rec_lock(lock),
    .i_irq_ack(ack), .i_req(req), .o_rsp(rsp), .o_diag_irq(irq),
    .o_input_state(state)
  );
  coupler_model cpl_u (
    .i_clk_sys(clk_sys), .o_req(req), .i_rsp(rsp), .o_stop_state(stop)
  );

  task automatic print_verdict();
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic w, input acc_mode_t m,
    input logic [15:0] a, input logic [7:0] s, input logic [4:0] off,
    input logic [7:0] wd, input logic [7:0] exp, input logic eerr);
    logic [7:0] got;
    logic er, tmo;
    cpl_u.xfer(w, m, a, s, off, wd, got, er, tmo);
    if (tmo) begin
      n_errors++;
      $display("MISMATCH t=%0t no answer", $time);
      print_verdict();
    end else begin
      chk8({7'h00, er}, {7'h00, eerr});
      if (!eerr)
        chk8(got, exp);
    end
  endtask
  task automatic rd(input acc_mode_t m, input logic [15:0] a,
    input logic [7:0] s, input logic [4:0] off, input logic [7:0] exp);
    acc(1'b0, m, a, s, off, 8'h00, exp, 1'b0);
  endtask
  task automatic rde(input acc_mode_t m, input logic [15:0] a,
    input logic [4:0] off);
    acc(1'b0, m, a, 8'h00, off, 8'h00, 8'h00, 1'b1);
  endtask
  task automatic wr(input acc_mode_t m, input logic [15:0] a,
    input logic [7:0] wd, input logic eerr);
    acc(1'b1, m, a, 8'h00, 5'd0, wd, 8'h00, eerr);
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic get_ts(output logic [31:0] ts);
    logic er, tmo;
    for (int i = 0; i < 4; i++) begin
      cpl_u.xfer(1'b0, ACC_ETHERCAT, 16'h5005, 8'h13, 5'(i), 8'h00,
        ts[8*i +: 8], er, tmo);
      chk8({7'h00, tmo | er}, 8'h00);
    end
  endtask
  function automatic logic [7:0] b8(input logic b);
    return {7'h00, b};
  endfunction

  initial begin
    repeat (4) @(posedge clk_sys);
    @(negedge clk_sys);
    rst_n = 1'b1;
    for (int i = 0; i < 6; i++) begin
      rd(ACC_CANOPEN, 16'h3100 + 16'(i), 8'h00, 5'd0, pexp[i]);
      rd(ACC_ETHERCAT, 16'h3100, 8'(i + 1), 5'd0, pexp[i]);
    end
    for (int i = 0; i < 20; i++) begin
      rd(ACC_RECORD, 16'h0001, 8'h00, 5'(i), dexp[i]);
      rd(ACC_CANOPEN, 16'h2f01, 8'h00, 5'(i), dexp[i]);
      if (i < 16)
        rd(ACC_ETHERCAT, 16'h5005, 8'(i + 2), 5'd0, dexp[i]);
    end
    rd(ACC_RECORD, 16'h0000, 8'h00, 5'd3, 8'h00);
    rde(ACC_RECORD, 16'h0000, 5'd4);
    rd(ACC_CANOPEN, 16'h2f00, 8'h00, 5'd0, 8'h00);
    rde(ACC_CANOPEN, 16'h2f00, 5'd4);
    rde(ACC_RECORD, 16'h0005, 5'd0);
    // Interrupt enable byte while running, then an illegal enable code
    wr(ACC_CANOPEN, 16'h3100, 8'h40, 1'b1);
    rd(ACC_CANOPEN, 16'h3100, 8'h00, 5'd0, 8'h00);
    cpl_u.set_stop(1'b1);
    wr(ACC_CANOPEN, 16'h3100, 8'h22, 1'b1);
    rd(ACC_RECORD, 16'h0001, 8'h00, 5'd0, 8'h80);
    wr(ACC_RECORD, 16'h0000, 8'h40, 1'b0);
    rd(ACC_CANOPEN, 16'h3100, 8'h00, 5'd0, 8'h40);
    rd(ACC_RECORD, 16'h0001, 8'h00, 5'd0, 8'h00);
    for (int c = 1; c < 8; c++) begin
      wr(ACC_RECORD, 16'h0081, {4'(c), 4'(c)}, 1'b0);
      rd(ACC_CANOPEN, 16'h3103, 8'h00, 5'd0, {4'(c), 4'(c)});
    end
    wr(ACC_RECORD, 16'h0081, 8'h18, 1'b1);
    wr(ACC_RECORD, 16'h0081, 8'h01, 1'b1);
    rd(ACC_RECORD, 16'h0081, 8'h00, 5'd0, 8'h77);
    rd(ACC_RECORD, 16'h0001, 8'h00, 5'd0, 8'h80);
    // Interrupts are enabled now, so the parameter error raised one
    chk8(b8(irq), 8'h01);
    ack = 1'b1;
    @(negedge clk_sys);
    ack = 1'b0;
    chk8(b8(irq), 8'h00);
    wr(ACC_RECORD, 16'h0081, 8'h11, 1'b0);
    wr(ACC_CANOPEN, 16'h3102, 8'h72, 1'b0);
    // Pair 0 gets 20 and 40 cycles, pair 1 keeps the 2500 cycle default
    in_ch = 8'h07;
    idle(32);
    chk8(state, 8'h01);
    idle(20);
    chk8(state, 8'h03);
    idle(1948);
    chk8(state, 8'h03);
    idle(600);
    chk8(state, 8'h07);
    wbrk = 8'h08;
    idle(10);
    rd(ACC_RECORD, 16'h0001, 8'h00, 5'd11, 8'h00);
    chk8(b8(irq), 8'h00);
    acc(1'b1, ACC_ETHERCAT, 16'h3100, 8'h02, 5'd0, 8'h18, 8'h00, 1'b0);
    idle(10);
    rd(ACC_RECORD, 16'h0001, 8'h00, 5'd11, 8'h10);
    rd(ACC_RECORD, 16'h0001, 8'h00, 5'd7, 8'h08);
    rd(ACC_RECORD, 16'h0001, 8'h00, 5'd0, 8'h0c);
    chk8(b8(irq), 8'h01);
    get_ts(ts1);
    chk8(b8(ts1 > 0 && ts1 <= 32'(cyc / 25)), 8'h01);
    ack = 1'b1;
    @(negedge clk_sys);
    ack = 1'b0;
    chk8(b8(irq), 8'h00);
    // Locked record keeps the old stamp across two new events
    lock = 1'b1;
    get_ts(ts1);
    aux = 1'b1;
    comm = 1'b1;
    fault = 1'b1;
    idle(10);
    wbrk = 8'h18;
    idle(10);
    get_ts(ts2);
    chk8(b8(ts2 === ts1), 8'h01);
    rd(ACC_RECORD, 16'h0001, 8'h00, 5'd0, 8'h1f);
    rd(ACC_RECORD, 16'h0001, 8'h00, 5'd3, 8'h18);
    chk8(b8(irq), 8'h01);
    lock = 1'b0;
    idle(3);
    get_ts(ts3);
    chk8(b8(ts3 > ts1), 8'h01);
    ack = 1'b1;
    @(negedge clk_sys);
    ack = 1'b0;
    rd(ACC_RECORD, 16'h0001, 8'h00, 5'd3, 8'h10);
    print_verdict();
  end
endmodule
